/* testbench.sv */
// Self-checking testbench for the unified cache and write buffer
`timescale 1ns/1ns
module testbench;
    import ucwb_pkg::*;
    logic       sys_clk, reset, ce, ctl_wr, cop_wr, secure_cache_kill, slow, err, rd_ready, rd_valid;
    logic       core_req, core_we, core_seq, core_lock, core_cachable, core_bufferable, core_ready, core_abort;
    logic       mem_req, mem_we, bus_lock_out, mem_ack, bus_error_in;
    logic [2:0] cop_op2;
    logic [3:0] ctl_wdata, ctl_state, cop_crm;
    ucwb_word_t core_addr, core_wdata, rd_data, mem_addr, mem_wdata, mem_rdata, a, d;
    ucwb_word_t wq[$], aq[$], rq[$], wa[9], wd[9];
    int         err_total, total_checks, rd_cnt, lock_cnt, ab_cnt, waited, n, wt[9];
    integer     seed = 32'h9e89;
    ucwb_top ucwb_top_i (.sys_clk, .reset, .ce, .ctl_wr, .ctl_wdata, .ctl_state, .cop_wr, .cop_op2, .cop_crm,
        .secure_cache_kill, .core_req, .core_we, .core_seq, .core_lock, .core_cachable, .core_bufferable,
        .core_addr, .core_wdata, .core_ready, .core_abort, .rd_valid, .rd_data, .rd_ready, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .bus_lock_out, .mem_ack, .mem_rdata, .bus_error_in);
    ucwb_mem_model ucwb_mem_model_i (.sys_clk, .reset, .mem_req, .mem_we, .mem_addr, .mem_ack, .mem_rdata,
        .bus_error_in, .slow, .err);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) #1 rd_ready = $random(seed);
    // Settled mid-cycle, so no race with the launching edge
    always @(negedge sys_clk) begin
        if (mem_req && mem_ack && mem_we) wq.push_back(mem_wdata);
        if (mem_req && mem_ack && mem_we) aq.push_back(mem_addr);
        if (mem_req && mem_ack && !mem_we) rd_cnt++;
        if (rd_valid && rd_ready) rq.push_back(rd_data);
        if (bus_lock_out) lock_cnt++;
        if (core_abort) ab_cnt++;
    end
    task automatic chk(input string nm, input ucwb_word_t e, input ucwb_word_t g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Memory partner answers every read with the inverted address
    function automatic ucwb_word_t mem_word(input ucwb_word_t ad);
        return ~ad;
    endfunction
    task automatic pulse(input logic c, input logic [3:0] v, input logic [2:0] o);
        @(posedge sys_clk) #1;
        if (c) {ctl_wr, ctl_wdata} = {1'b1, v};
        else {cop_wr, cop_crm, cop_op2} = {1'b1, v, o};
        @(posedge sys_clk) #1;
        {ctl_wr, cop_wr} = 2'b00;
    endtask
    // Attribute order: lock, seq, cachable, bufferable
    task automatic acc(input logic we, input ucwb_word_t ad, input ucwb_word_t dt, input logic [3:0] at);
        @(posedge sys_clk) #1;
        {core_req, core_we, core_addr, core_wdata} = {1'b1, we, ad, dt};
        {core_lock, core_seq, core_cachable, core_bufferable} = at;
        waited = 0;
        @(negedge sys_clk);
        while (core_ready !== 1'b1 && waited < 300) begin
            waited++;
            @(negedge sys_clk);
        end
        chk("ready timeout", 32'h0, 32'(waited / 300));
        @(posedge sys_clk) #1;
        core_req = 1'b0;
    endtask
    task automatic rd(input ucwb_word_t ad, input ucwb_word_t e, input logic [3:0] at);
        acc(1'b0, ad, 32'h0, at);
        for (int j = 0; j < 40 && rq.size() == 0; j++) @(negedge sys_clk);
        chk("rdata", e, rq.size() ? rq.pop_front() : 32'hx);
    endtask
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(100 * 50000);
        err_total++;
        stop_test();
    end
    initial begin
        {reset, ce, ctl_wr, cop_wr, secure_cache_kill, slow, err, rd_ready, core_req} = 9'h180;
        {core_we, core_seq, core_lock, core_cachable, core_bufferable, cop_op2} = 8'h0;
        {ctl_wdata, cop_crm, core_addr, core_wdata} = 72'h0;
        repeat (4) @(posedge sys_clk);
        #1 reset = 1'b0;
        @(negedge sys_clk) chk("ctl_state", 32'h0, 32'(ctl_state));
        pulse(1'b1, 4'hd, 3'h0);
        @(negedge sys_clk) chk("ctl_state", 32'hd, 32'(ctl_state));
        a = ($random(seed) & 32'hfffffff0) | 32'h4;
        n = rd_cnt;
        rd(a, ~a, 4'b0010);
        chk("fill", n + 4, rd_cnt);
        rd(a + 4, ~(a + 4), 4'b0000);
        chk("hit", n + 4, rd_cnt);
        // Other set, so the random victim can never evict the first line
        rd(a ^ 32'h1010, ~(a ^ 32'h1010), 4'b0000);
        rd(a ^ 32'h1010, ~(a ^ 32'h1010), 4'b0010);
        chk("uncached", n + 9, rd_cnt);
        pulse(1'b0, 4'h6, 3'h0);
        rd(a, ~a, 4'b0010);
        chk("bad op", n + 9, rd_cnt);
        pulse(1'b0, 4'h7, 3'h0);
        rd(a, ~a, 4'b0010);
        chk("flush", n + 13, rd_cnt);
        lock_cnt = 0;
        d = $random(seed);
        rd(a, ~a, 4'b1010);
        chk("lock rd", n + 14, rd_cnt);
        acc(1'b1, a, d, 4'b1010);
        chk("lock", 32'h1, 32'(lock_cnt > 1));
        rd(a, d, 4'b0010);
        chk("lock wr", n + 14, rd_cnt);
        chk("thru", d, wq.pop_back());
        pulse(1'b1, 4'hc, 3'h0);
        @(posedge sys_clk) #1 secure_cache_kill = 1'b1;
        rd(a, ~a, 4'b0010);
        chk("kill", 32'h1, 32'(rd_cnt > n + 14));
        @(posedge sys_clk) #1 secure_cache_kill = 1'b0;
        pulse(1'b1, 4'h9, 3'h0);
        pulse(1'b0, 4'h7, 3'h0);
        n = rd_cnt;
        rd(a, mem_word(a), 4'b0010);
        rd(a, mem_word(a), 4'b0010);
        chk("no alloc", n + 2, rd_cnt);
        {slow, err, ab_cnt} = {2'b11, 32'h0};
        // Case 0 runs out of address slots, case 1 out of data slots
        for (int k = 0; k < 2; k++) begin
            pulse(1'b1, 4'hd, 3'h0);
            wq.delete();
            aq.delete();
            n = k ? 9 : 5;
            a = $random(seed) & 32'hfffffffc;
            for (int i = 0; i < n; i++) begin
                wa[i] = k ? a + 4 * i : $random(seed) & 32'hfffffffc;
                wd[i] = $random(seed);
                acc(1'b1, wa[i], wd[i], {1'b0, k != 0 && i > 0, 2'b01});
                wt[i] = waited;
            end
            for (int i = 0; i < n - 1; i++) chk("no wait", 32'h0, 32'(wt[i]));
            chk("stall", 32'h1, 32'(wt[n - 1] > 0));
            pulse(1'b1, 4'h5, 3'h0);
            for (int j = 0; j < 900 && wq.size() < n; j++) @(negedge sys_clk);
            for (int i = 0; i < n; i++) chk("wr data", wd[i], wq.size() ? wq.pop_front() : 32'hx);
            for (int i = 0; i < n; i++) chk("wr addr", wa[i], aq.size() ? aq.pop_front() : 32'hx);
        end
        chk("abort", 32'h0, 32'(ab_cnt));
        err = 1'b0;
        pulse(1'b1, 4'hd, 3'h0);
        acc(1'b1, a, 32'h1, 4'b0001);
        acc(1'b1, a + 4, 32'h2, 4'b0101);
        acc(1'b1, a ^ 32'h40, 32'h3, 4'b0000);
        chk("unbuf", 32'h3, 32'(wq.size()));
        pulse(1'b1, 4'h5, 3'h0);
        acc(1'b1, a, 32'h4, 4'b0001);
        chk("wb off", 32'h4, 32'(wq.size()));
        // Reset in mid-run with a resident line and a queued write
        pulse(1'b1, 4'hd, 3'h0);
        rd(a, mem_word(a), 4'b0010);
        acc(1'b1, a ^ 32'h80, 32'h5, 4'b0001);
        wq.delete();
        @(posedge sys_clk) #1 reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        @(negedge sys_clk) chk("ctl_state", 32'h0, 32'(ctl_state));
        pulse(1'b1, 4'hd, 3'h0);
        n = rd_cnt;
        rd(a, mem_word(a), 4'b0010);
        chk("reset inv", n + 4, rd_cnt);
        chk("discard", 32'h0, 32'(wq.size()));
        stop_test();
    end
endmodule

/* ucwb_mem_model.sv */
// External memory partner for the unified cache and write buffer
`timescale 1ns/1ns
module ucwb_mem_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Bus from the block
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    output      logic        mem_ack,
    output      logic [31:0] mem_rdata,
    output      logic        bus_error_in,
    // Test controls
    input  wire logic        slow,
    input  wire logic        err
);
    int wait_n = 0;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0;
        bus_error_in = 1'b0;
    end
    always @(posedge sys_clk) begin
        #1;
        mem_ack = 1'b0;
        bus_error_in = 1'b0;
        // Read data is not held between acks
        mem_rdata = ~mem_rdata;
        if (reset) begin
            wait_n = 0;
        end else if (mem_req) begin
            // Slow mode keeps buffered entries resident long enough to fill the buffer
            if (wait_n >= (slow ? 20 : 1)) begin
                mem_ack = 1'b1;
                mem_rdata = ~mem_addr;
                bus_error_in = err & mem_we;
                wait_n = 0;
            end else begin
                wait_n++;
            end
        end
    end
endmodule

/* ucwb_pkg.sv */
// Types for the unified cache and write buffer
package ucwb_pkg;
    typedef enum logic [1:0] {S_IDLE, S_DRAIN, S_EXT, S_FILL} ucwb_state_t;
    typedef logic [31:0] ucwb_word_t;
    typedef logic [20:0] ucwb_tag_t;
    typedef logic [8:0]  ucwb_line_t;
endpackage

/* ucwb_regs.svh */
// Constants for the unified cache and write buffer
`ifndef UCWB_REGS_SVH
`define UCWB_REGS_SVH
`define UCWB_LINES        512
`define UCWB_LINE_WORDS   4
`define UCWB_IDX_HI       10
`define UCWB_IDX_LO       4
`define UCWB_TAG_HI       31
`define UCWB_TAG_LO       11
`define UCWB_WRD_HI       3
`define UCWB_WRD_LO       2
`define UCWB_FILL_LAST    2'h3
`define UCWB_CTL_MMU      0
`define UCWB_CTL_CACHE    2
`define UCWB_CTL_WBUF     3
`define UCWB_CTL_RESET    4'h0
`define UCWB_COP_OP2_INV  3'h0
`define UCWB_COP_CRM_INV  4'h7
`define UCWB_LFSR_SEED    8'h01
`define UCWB_WB_WORDS     8
`define UCWB_WB_ADDRS     4
`define UCWB_WB_WORDS_MAX 4'h8
`define UCWB_WB_ADDRS_MAX 3'h4
`define UCWB_SK_DEPTH     2'h2
`endif

/* ucwb_top.sv */
// Unified write-through cache with write buffer and read skid buffer
`timescale 1ns/1ns
`include "ucwb_regs.svh"
module ucwb_top import ucwb_pkg::*; (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // Control register and cache operations
    input  wire logic        ctl_wr,
    input  wire logic [3:0]  ctl_wdata,
    output      logic [3:0]  ctl_state,
    input  wire logic        cop_wr,
    input  wire logic [2:0]  cop_op2,
    input  wire logic [3:0]  cop_crm,
    input  wire logic        secure_cache_kill,
    // Core request
    input  wire logic        core_req,
    input  wire logic        core_we,
    input  wire logic        core_seq,
    input  wire logic        core_lock,
    input  wire logic        core_cachable,
    input  wire logic        core_bufferable,
    input  wire logic [31:0] core_addr,
    input  wire logic [31:0] core_wdata,
    output      logic        core_ready,
    output      logic        core_abort,
    // Read data to core
    output      logic        rd_valid,
    output      logic [31:0] rd_data,
    input  wire logic        rd_ready,
    // External memory bus
    output      logic        mem_req,
    output      logic        mem_we,
    output      logic [31:0] mem_addr,
    output      logic [31:0] mem_wdata,
    output      logic        bus_lock_out,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        bus_error_in
);
    ucwb_wb_if wb ();

    ucwb_state_t state_q, state_d;
    logic [3:0]  ctrl_q, ctrl_d;
    ucwb_word_t  addr_q, addr_d, wdata_q, wdata_d, fword_q, fword_d;
    logic        we_q, we_d, lkreq_q, lkreq_d, cach_q, cach_d, lock_q, lock_d;
    logic [1:0]  fcnt_q, fcnt_d, vway_q, vway_d;
    logic [7:0]  lfsr_q, lfsr_d;
    logic        abort_q, abort_d;
    logic [`UCWB_LINES-1:0] valid_q, valid_d;
    ucwb_tag_t   tag_q  [`UCWB_LINES];
    ucwb_word_t  data_q [`UCWB_LINES][`UCWB_LINE_WORDS];
    ucwb_word_t  cur_addr, cur_wdata, hit_data, sk_pdata;
    logic [6:0]  cur_set;
    logic [3:0]  hit_w;
    logic [1:0]  hit_way;
    logic        hit, done, sk_push, sk_ready, mreq, fill_we, tag_we, upd_we, flush, fsm_own;
    ucwb_line_t  fline, hline;
    ucwb_word_t  sk_q [2];
    logic        sk_head_q, sk_head_d, sk_pop;
    logic [1:0]  sk_cnt_q, sk_cnt_d;

    ucwb_wbuf u_wbuf (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ce      (ce),
        .wb      (wb.store)
    );

    // Lookup uses the held address once the request left idle
    assign cur_addr  = (state_q == S_IDLE) ? core_addr : addr_q;
    assign cur_wdata = (state_q == S_IDLE) ? core_wdata : wdata_q;
    assign cur_set   = cur_addr[`UCWB_IDX_HI:`UCWB_IDX_LO];
    assign fline     = {addr_q[`UCWB_IDX_HI:`UCWB_IDX_LO], vway_q};
    assign hline     = {cur_set, hit_way};

    // Search ignores enable and cachable; kill masks every way
    genvar w;
    generate
        for (w = 0; w < 4; w++) begin : g_way
            assign hit_w[w] = valid_q[{cur_set, 2'(w)}] && !secure_cache_kill
                              && tag_q[{cur_set, 2'(w)}] == cur_addr[`UCWB_TAG_HI:`UCWB_TAG_LO];
        end
    endgenerate

    always_comb begin
        hit_way = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (hit_w[i]) begin
                hit_way = 2'(i);
            end
        end
    end
    assign hit      = |hit_w;
    assign hit_data = data_q[hline][cur_addr[`UCWB_WRD_HI:`UCWB_WRD_LO]];
    assign flush    = cop_wr && cop_op2 == `UCWB_COP_OP2_INV && cop_crm == `UCWB_COP_CRM_INV;

    // Main sequencer
    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        we_d    = we_q;
        lkreq_d = lkreq_q;
        cach_d  = cach_q;
        vway_d  = vway_q;
        fcnt_d  = fcnt_q;
        fword_d = fword_q;
        lock_d  = lock_q;
        done    = 1'b0;
        sk_push = 1'b0;
        sk_pdata = mem_rdata;
        mreq    = 1'b0;
        fill_we = 1'b0;
        tag_we  = 1'b0;
        upd_we  = 1'b0;
        wb.push_valid = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                if (core_req) begin
                    addr_d  = core_addr;
                    wdata_d = core_wdata;
                    we_d    = core_we;
                    lkreq_d = core_lock;
                    cach_d  = core_cachable;
                    vway_d  = lfsr_q[1:0];
                    if (!core_we && !core_lock && hit) begin
                        sk_push  = sk_ready;
                        sk_pdata = hit_data;
                        done     = sk_ready;
                    end else if (core_we && !core_lock && ctrl_q[`UCWB_CTL_WBUF] && core_bufferable) begin
                        wb.push_valid = ce;
                        done   = wb.push_ready;
                        upd_we = hit && wb.push_ready;
                    end else begin
                        state_d = S_DRAIN;
                    end
                end
            end
            S_DRAIN: begin
                fcnt_d = 2'h0;
                if (wb.empty) begin
                    if (!we_q && !lkreq_q && cach_q && ctrl_q[`UCWB_CTL_CACHE] && !secure_cache_kill) begin
                        state_d = S_FILL;
                    end else begin
                        state_d = S_EXT;
                        lock_d  = lock_q || lkreq_q;
                    end
                end
            end
            S_EXT: begin
                // Read waits for skid room since the ack is a single pulse
                mreq = we_q || sk_ready;
                if (mem_ack) begin
                    done    = 1'b1;
                    state_d = S_IDLE;
                    lock_d  = lkreq_q && !we_q;
                    sk_push = !we_q;
                    upd_we  = we_q && hit;
                end
            end
            S_FILL: begin
                mreq = sk_ready;
                if (mem_ack) begin
                    fill_we = 1'b1;
                    fcnt_d  = fcnt_q + 2'h1;
                    if (fcnt_q == addr_q[`UCWB_WRD_HI:`UCWB_WRD_LO]) begin
                        fword_d = mem_rdata;
                    end
                    if (fcnt_q == `UCWB_FILL_LAST) begin
                        tag_we   = 1'b1;
                        done     = 1'b1;
                        sk_push  = 1'b1;
                        sk_pdata = (fcnt_q == addr_q[`UCWB_WRD_HI:`UCWB_WRD_LO]) ? mem_rdata : fword_q;
                        state_d  = S_IDLE;
                    end
                end
            end
        endcase
    end

    assign core_ready    = ce && done;
    assign wb.push_seq   = core_seq;
    assign wb.push_addr  = core_addr;
    assign wb.push_data  = core_wdata;

    // Bus belongs to the buffer unless the sequencer is out on it
    assign fsm_own    = state_q == S_EXT || state_q == S_FILL;
    assign mem_req    = fsm_own ? mreq : wb.bus_req;
    assign mem_we     = fsm_own ? (state_q == S_EXT && we_q) : 1'b1;
    assign mem_addr   = (state_q == S_FILL) ? {addr_q[31:4], fcnt_q, 2'h0} : (fsm_own ? addr_q : wb.bus_addr);
    assign mem_wdata  = fsm_own ? wdata_q : wb.bus_data;
    assign wb.bus_ack = !fsm_own && mem_ack;
    assign abort_d    = ce && fsm_own && mem_ack && bus_error_in;
    assign core_abort = abort_q;
    assign bus_lock_out = lock_q;
    assign ctl_state  = ctrl_q;

    // Both enable bits may arrive in the same write
    assign ctrl_d = ctl_wr ? ctl_wdata : ctrl_q;
    assign lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};

    // Flush wins over a fill completing in the same cycle
    always_comb begin
        valid_d = valid_q;
        if (fill_we && fcnt_q == 2'h0) begin
            valid_d[fline] = 1'b0;
        end
        if (tag_we) begin
            valid_d[fline] = 1'b1;
        end
        if (flush) begin
            valid_d = '0;
        end
    end

    // Read skid buffer
    assign sk_ready  = sk_cnt_q != `UCWB_SK_DEPTH;
    assign rd_valid  = sk_cnt_q != 2'h0;
    assign rd_data   = sk_q[sk_head_q];
    assign sk_pop    = ce && rd_valid && rd_ready;
    assign sk_head_d = sk_head_q ^ sk_pop;
    assign sk_cnt_d  = sk_cnt_q + {1'b0, ce && sk_push} - {1'b0, sk_pop};

    always_ff @(posedge sys_clk) begin
        if (ce && sk_push) begin
            sk_q[sk_head_q ^ sk_cnt_q[0]] <= sk_pdata;
        end
    end

    // Tag and data arrays need no reset: valid bits guard them
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            if (fill_we) begin
                data_q[fline][fcnt_q] <= mem_rdata;
            end
            if (upd_we) begin
                data_q[hline][cur_addr[`UCWB_WRD_HI:`UCWB_WRD_LO]] <= cur_wdata;
            end
            if (tag_we) begin
                tag_q[fline] <= addr_q[`UCWB_TAG_HI:`UCWB_TAG_LO];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q   <= S_IDLE;
            ctrl_q    <= `UCWB_CTL_RESET;
            valid_q   <= '0;
            lfsr_q    <= `UCWB_LFSR_SEED;
            addr_q    <= 32'h0;
            wdata_q   <= 32'h0;
            fword_q   <= 32'h0;
            we_q      <= 1'b0;
            lkreq_q   <= 1'b0;
            cach_q    <= 1'b0;
            lock_q    <= 1'b0;
            fcnt_q    <= 2'h0;
            vway_q    <= 2'h0;
            abort_q   <= 1'b0;
            sk_head_q <= 1'b0;
            sk_cnt_q  <= 2'h0;
        end else if (ce) begin
            state_q   <= state_d;
            ctrl_q    <= ctrl_d;
            valid_q   <= valid_d;
            lfsr_q    <= lfsr_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            fword_q   <= fword_d;
            we_q      <= we_d;
            lkreq_q   <= lkreq_d;
            cach_q    <= cach_d;
            lock_q    <= lock_d;
            fcnt_q    <= fcnt_d;
            vway_q    <= vway_d;
            abort_q   <= abort_d;
            sk_head_q <= sk_head_d;
            sk_cnt_q  <= sk_cnt_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence lock_read_done;
        ce && state_q == S_EXT && mem_ack && lkreq_q && !we_q;
    endsequence

    kill_no_hit_a: assert property (secure_cache_kill |-> !hit && !upd_we)
        else $error("hit produced while cache killed");
    flush_all_a: assert property (ce && flush |=> valid_q == '0)
        else $error("cache operation left a valid line");
    reset_clear_a: assert property ($fell(reset) |-> ctrl_q == `UCWB_CTL_RESET && valid_q == '0)
        else $error("enables or lines survived reset");
    lock_span_a: assert property (lock_read_done |=> bus_lock_out && state_q == S_IDLE)
        else $error("bus lock dropped between locked phases");
    locked_ext_a: assert property (state_q == S_IDLE && core_req && core_lock |-> !core_ready)
        else $error("locked access served without external read");
    unbuf_wait_a: assert property (core_ready && state_q == S_EXT |-> wb.empty && mem_ack)
        else $error("unbuffered access finished early");
    fill_four_a: assert property (core_ready && state_q == S_FILL |-> fcnt_q == `UCWB_FILL_LAST)
        else $error("line fill finished before fourth word");
    no_write_alloc_a: assert property (tag_we |-> state_q == S_FILL && !we_q)
        else $error("line allocated outside read miss");
    uncached_keep_a: assert property (state_q == S_EXT |-> !fill_we && !tag_we)
        else $error("uncachable read loaded the cache");
    buf_gate_a: assert property (wb.push_valid |-> ctrl_q[`UCWB_CTL_WBUF] && core_bufferable)
        else $error("write buffered without both enables");
    lfsr_live_a: assert property (ce |=> lfsr_q != 8'h0 && lfsr_q != $past(lfsr_q))
        else $error("replacement counter stuck");
    err_ignore_a: assert property (!fsm_own && mem_ack |=> !core_abort)
        else $error("buffered write reported an abort");
endmodule

/* ucwb_wb_if.sv */
// Link between the cache controller and its write buffer
`timescale 1ns/1ns
interface ucwb_wb_if;
    import ucwb_pkg::*;
    logic       push_valid;
    logic       push_seq;
    ucwb_word_t push_addr;
    ucwb_word_t push_data;
    logic       push_ready;
    logic       empty;
    logic       bus_req;
    ucwb_word_t bus_addr;
    ucwb_word_t bus_data;
    logic       bus_ack;
    modport ctl   (output push_valid, push_seq, push_addr, push_data, bus_ack,
                   input  push_ready, empty, bus_req, bus_addr, bus_data);
    modport store (input  push_valid, push_seq, push_addr, push_data, bus_ack,
                   output push_ready, empty, bus_req, bus_addr, bus_data);
endinterface

/* ucwb_wbuf.sv */
// Write buffer: eight shared data slots, four address slots
`timescale 1ns/1ns
`include "ucwb_regs.svh"
module ucwb_wbuf import ucwb_pkg::*; (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    // Controller side
    ucwb_wb_if.store wb
);
    ucwb_word_t dat_q  [`UCWB_WB_WORDS];
    ucwb_word_t adr_q  [`UCWB_WB_ADDRS];
    ucwb_word_t adr_d  [`UCWB_WB_ADDRS];
    logic [3:0] alen_q [`UCWB_WB_ADDRS];
    logic [3:0] alen_d [`UCWB_WB_ADDRS];
    logic [2:0] dhead_q, dhead_d, dtail_q, dtail_d;
    logic [3:0] dcnt_q,  dcnt_d;
    logic [1:0] ahead_q, ahead_d, atail_q, atail_d;
    logic [2:0] acnt_q,  acnt_d;
    logic       app, push, ack, pop;
    logic [1:0] newest;

    // A sequential word joins the newest address while one is queued
    assign newest        = atail_q - 2'h1;
    assign app           = wb.push_seq && (acnt_q != 3'h0);
    assign wb.push_ready = app ? (dcnt_q != `UCWB_WB_WORDS_MAX)
                               : (dcnt_q != `UCWB_WB_WORDS_MAX && acnt_q != `UCWB_WB_ADDRS_MAX);
    assign push          = ce && wb.push_valid && wb.push_ready;
    assign ack           = ce && wb.bus_ack && wb.bus_req;
    // Head only retires when no word is joining it this cycle
    assign pop           = ack && alen_q[ahead_q] == 4'h1 && !(push && app && newest == ahead_q);
    // Drains while anything is queued, whatever the enable says
    assign wb.bus_req    = acnt_q != 3'h0;
    assign wb.bus_addr   = adr_q[ahead_q];
    assign wb.bus_data   = dat_q[dhead_q];
    assign wb.empty      = acnt_q == 3'h0;

    always_comb begin
        dhead_d = dhead_q + {2'h0, ack};
        dtail_d = dtail_q + {2'h0, push};
        dcnt_d  = dcnt_q + {3'h0, push} - {3'h0, ack};
        ahead_d = ahead_q + {1'b0, pop};
        atail_d = atail_q + {1'b0, push && !app};
        acnt_d  = acnt_q + {2'h0, push && !app} - {2'h0, pop};
    end

    genvar e;
    generate
        for (e = 0; e < `UCWB_WB_ADDRS; e++) begin : g_ent
            always_comb begin
                adr_d[e]  = adr_q[e];
                alen_d[e] = alen_q[e];
                if (ack && ahead_q == 2'(e)) begin
                    adr_d[e]  = adr_q[e] + 32'h4;
                    alen_d[e] = alen_q[e] - 4'h1;
                end
                if (push && app && newest == 2'(e)) begin
                    alen_d[e] = alen_d[e] + 4'h1;
                end
                if (push && !app && atail_q == 2'(e)) begin
                    adr_d[e]  = wb.push_addr;
                    alen_d[e] = 4'h1;
                end
            end
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    adr_q[e]  <= 32'h0;
                    alen_q[e] <= 4'h0;
                end else if (ce) begin
                    adr_q[e]  <= adr_d[e];
                    alen_q[e] <= alen_d[e];
                end
            end
        end
    endgenerate

    // Data words need no reset: counts guard them
    always_ff @(posedge sys_clk) begin
        if (push) begin
            dat_q[dtail_q] <= wb.push_data;
        end
    end

    // Reset discards all queued writes
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dhead_q <= 3'h0;
            dtail_q <= 3'h0;
            dcnt_q  <= 4'h0;
            ahead_q <= 2'h0;
            atail_q <= 2'h0;
            acnt_q  <= 3'h0;
        end else if (ce) begin
            dhead_q <= dhead_d;
            dtail_q <= dtail_d;
            dcnt_q  <= dcnt_d;
            ahead_q <= ahead_d;
            atail_q <= atail_d;
            acnt_q  <= acnt_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    slot_limits_a: assert property (dcnt_q <= `UCWB_WB_WORDS_MAX && acnt_q <= `UCWB_WB_ADDRS_MAX)
        else $error("write buffer slot count exceeded");
    full_stall_a: assert property (dcnt_q == `UCWB_WB_WORDS_MAX |-> !wb.push_ready)
        else $error("push allowed with all data slots used");
    seq_slot_a: assert property (push && app && !pop |=> acnt_q == $past(acnt_q) && dcnt_q != 4'h0)
        else $error("sequential word took an address slot");
    words_cover_a: assert property (dcnt_q >= {1'b0, acnt_q})
        else $error("address slot without data");
    drain_hold_a: assert property (wb.bus_req && !ack |=> wb.bus_req)
        else $error("queued write dropped before completion");
endmodule
